// ---- include/bit_timing_map.vh ----
// Register offsets, fields, reset values and timing counts of the bit-timing block
`ifndef BIT_TIMING_MAP_VH
`define BIT_TIMING_MAP_VH

`define REG_CTRL 4'h0
`define REG_CMD 4'h4
`define REG_STATUS 4'h8
`define REG_TIMING 4'hC

`define CTRL_CODE_LSB 0
`define CTRL_CODE_MSB 5
`define CTRL_RATE_LSB 8
`define CTRL_RATE_MSB 13
`define CODE_RST 6'h00
`define RATE_RST 6'h01

`define CMD_OP_MSB 2
`define CMD_BIT 3
`define OP_START 3'h1
`define OP_BIT 3'h2
`define OP_STOP 3'h3
`define OP_RSTART 3'h4

`define ST_BUSY 0
`define ST_RX 1
`define ST_SCL 2
`define ST_SDA 3

`define STOP_SETUP_CLK 17'h00004

`endif

// ---- rtl/divider_lookup.v ----
// Divider code to decimal bit-clock divider lookup, registered output
`timescale 1ns/1ps
module divider_lookup
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Code in, divider out
    input wire [5:0] scl_divider_code,
    output reg [15:0] divider_value
);

reg [15:0] value_nxt;

always @*
begin
    case (scl_divider_code)
        6'h00: value_nxt = 16'h0120;
        6'h01: value_nxt = 16'h0140;
        6'h02: value_nxt = 16'h0180;
        6'h03: value_nxt = 16'h01C0;
        6'h04: value_nxt = 16'h0240;
        6'h05: value_nxt = 16'h0280;
        6'h06: value_nxt = 16'h0300;
        6'h07: value_nxt = 16'h0380;
        6'h08: value_nxt = 16'h0480;
        6'h09: value_nxt = 16'h0500;
        6'h0A: value_nxt = 16'h0600;
        6'h0B: value_nxt = 16'h0700;
        6'h0C: value_nxt = 16'h0900;
        6'h0D: value_nxt = 16'h0A00;
        6'h0E: value_nxt = 16'h0C00;
        6'h0F: value_nxt = 16'h0E00;
        6'h10: value_nxt = 16'h1200;
        6'h11: value_nxt = 16'h1400;
        6'h12: value_nxt = 16'h1800;
        6'h13: value_nxt = 16'h1C00;
        6'h14: value_nxt = 16'h2400;
        6'h15: value_nxt = 16'h2800;
        6'h16: value_nxt = 16'h3000;
        6'h17: value_nxt = 16'h3800;
        6'h18: value_nxt = 16'h4800;
        6'h19: value_nxt = 16'h5000;
        6'h1A: value_nxt = 16'h6000;
        6'h1B: value_nxt = 16'h7000;
        6'h1C: value_nxt = 16'h9000;
        6'h1D: value_nxt = 16'hA000;
        6'h1E: value_nxt = 16'hC000;
        6'h1F: value_nxt = 16'hF000;
        6'h20: value_nxt = 16'h00A0;
        6'h21: value_nxt = 16'h00C0;
        6'h22: value_nxt = 16'h00E0;
        6'h23: value_nxt = 16'h0100;
        6'h24: value_nxt = 16'h0140;
        6'h25: value_nxt = 16'h0180;
        6'h26: value_nxt = 16'h01E0;
        6'h27: value_nxt = 16'h0200;
        6'h28: value_nxt = 16'h0280;
        6'h29: value_nxt = 16'h0300;
        6'h2A: value_nxt = 16'h03C0;
        6'h2B: value_nxt = 16'h0400;
        6'h2C: value_nxt = 16'h0500;
        6'h2D: value_nxt = 16'h0600;
        6'h2E: value_nxt = 16'h0780;
        6'h2F: value_nxt = 16'h0800;
        6'h30: value_nxt = 16'h0A00;
        6'h31: value_nxt = 16'h0C00;
        6'h32: value_nxt = 16'h0F00;
        6'h33: value_nxt = 16'h1000;
        6'h34: value_nxt = 16'h1400;
        6'h35: value_nxt = 16'h1800;
        6'h36: value_nxt = 16'h1E00;
        6'h37: value_nxt = 16'h2000;
        6'h38: value_nxt = 16'h2800;
        6'h39: value_nxt = 16'h3000;
        6'h3A: value_nxt = 16'h3C00;
        6'h3B: value_nxt = 16'h4000;
        6'h3C: value_nxt = 16'h5000;
        6'h3D: value_nxt = 16'h6000;
        6'h3E: value_nxt = 16'h7800;
        6'h3F: value_nxt = 16'h8000;
        default: value_nxt = 16'h0120;
    endcase
end

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        divider_value <= 16'h0120;
    else
        divider_value <= value_nxt;
end

endmodule // divider_lookup

// ---- rtl/bus_input_filter.v ----
// Digital glitch filter for one incoming bus line, stepped by the sample tick
`timescale 1ns/1ps
module bus_input_filter
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Sample tick and raw line
    input wire sample_tick,
    input wire line_in,
    // Qualified line
    output reg line_q
);

reg s1_r;
reg s2_r;

// Two ticks of agreement plus one output register: at most rate*2+1 clocks of delay
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
        line_q <= 1'b1;
    end
    else
    begin
        if (sample_tick)
        begin
            s1_r <= line_in;
            s2_r <= s1_r;
        end
        if (s1_r == s2_r)
            line_q <= s2_r;
    end
end

endmodule // bus_input_filter

// ---- rtl/bit_timing_ctrl.v ----
// Two-wire bit-timing generator with input qualifier and Wishbone registers
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "bit_timing_map.vh"

module bit_timing_ctrl
(
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Bus clock line
    input wire scl_i,
    output reg scl_o,
    output reg scl_oe,
    // Bus data line
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe
);

localparam [3:0] S_IDLE = 4'h1;
localparam [3:0] S_START = 4'h2;
localparam [3:0] S_LOW = 4'h4;
localparam [3:0] S_HIGH = 4'h8;

reg rst_meta_r;
reg rst_n_r;
reg [5:0] scl_divider_code_r;
reg [5:0] filter_sample_rate_r;
reg [5:0] tick_cnt_r;
reg sample_tick_r;
reg [3:0] state_r;
reg [2:0] op_r;
reg bit_r;
reg rx_r;
reg [16:0] cnt_r;
reg [16:0] hold_r;
reg [16:0] start_hold_r;
reg [16:0] half_r;

wire [15:0] divider_value;
wire scl_f;
wire sda_f;
wire bus_req;
wire wr_req;
reg [16:0] hold_nxt;
reg [16:0] hold_eff;
reg [16:0] high_target;
reg sda_drive_low;

// Release reset through two flops so the deassertion is clean
always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        rst_meta_r <= 1'b0;
        rst_n_r <= 1'b0;
    end
    else
    begin
        rst_meta_r <= 1'b1;
        rst_n_r <= rst_meta_r;
    end
end

divider_lookup u_lookup
(
    .clk(clk),
    .rst_n(rst_n_r),
    .scl_divider_code(scl_divider_code_r),
    .divider_value(divider_value)
);

// Sample tick every filter_sample_rate clocks; a rate of zero acts as one
always @(posedge clk or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        tick_cnt_r <= 6'h00;
        sample_tick_r <= 1'b0;
    end
    else if (tick_cnt_r + 6'h01 >= filter_sample_rate_r)
    begin
        tick_cnt_r <= 6'h00;
        sample_tick_r <= 1'b1;
    end
    else
    begin
        tick_cnt_r <= tick_cnt_r + 6'h01;
        sample_tick_r <= 1'b0;
    end
end

bus_input_filter u_scl_filter
(
    .clk(clk),
    .rst_n(rst_n_r),
    .sample_tick(sample_tick_r),
    .line_in(scl_i),
    .line_q(scl_f)
);

bus_input_filter u_sda_filter
(
    .clk(clk),
    .rst_n(rst_n_r),
    .sample_tick(sample_tick_r),
    .line_in(sda_i),
    .line_q(sda_f)
);

function [16:0] start_hold_f;
    input [15:0] d;
    input b5;
    reg [16:0] v;
    integer i;
    begin
        v = {5'h00, d[15:4]};
        for (i = 0; i < 16; i = i + 1)
        begin
            if ((!b5 && v >= 17'h00010) || (b5 && v >= 17'h00009))
                v = v >> 1;
        end
        if (v == 17'h00000)
            v = 17'h00001;
        start_hold_f = v;
    end
endfunction

always @*
begin
    case ({scl_divider_code_r[5], scl_divider_code_r[1]})
        2'b10: hold_nxt = 17'h00008 + (17'h00010 << scl_divider_code_r[4:2]);
        2'b11: hold_nxt = 17'h00008 + ((17'h00010 << scl_divider_code_r[4:2]) << 1);
        2'b00: hold_nxt = 17'h00008 + (17'h00010 << scl_divider_code_r[4:2]) * 17'h00003;
        default: hold_nxt = 17'h00008 + ((17'h00010 << scl_divider_code_r[4:2]) << 2);
    endcase
end

// Derived counts follow the code; the lookup adds one cycle of latency
always @(posedge clk or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        hold_r <= 17'h00008;
        start_hold_r <= 17'h00001;
        half_r <= 17'h00090;
    end
    else
    begin
        hold_r <= hold_nxt;
        start_hold_r <= start_hold_f(divider_value, scl_divider_code_r[5]);
        half_r <= {2'b00, divider_value[15:1]};
    end
end

// Hold longer than the low half would eat the setup; clamp it inside the low phase
always @*
begin
    if (hold_r >= half_r)
        hold_eff = half_r - 17'h00001;
    else
        hold_eff = hold_r;
    case (op_r)
        `OP_BIT: high_target = half_r;
        `OP_STOP: high_target = `STOP_SETUP_CLK;
        default: high_target = {1'b0, divider_value} + start_hold_r;
    endcase
    case (op_r)
        `OP_BIT: sda_drive_low = !bit_r;
        `OP_STOP: sda_drive_low = 1'b1;
        default: sda_drive_low = 1'b0;
    endcase
end

assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
assign wr_req = bus_req && wb_we_i;

// Sequencer: every phase restarts its counter; only the high phase waits on the filtered clock line, other phases count clocks
always @(posedge clk or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        state_r <= S_IDLE;
        op_r <= `OP_START;
        bit_r <= 1'b1;
        rx_r <= 1'b0;
        cnt_r <= 17'h00000;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        scl_o <= 1'b0;
        sda_o <= 1'b0;
    end
    else
    begin
        scl_o <= 1'b0;
        sda_o <= 1'b0;
        case (state_r)
            S_IDLE:
            begin
                cnt_r <= 17'h00000;
                if (wr_req && wb_adr_i == `REG_CMD && wb_sel_i[0])
                begin
                    op_r <= wb_dat_i[`CMD_OP_MSB:0];
                    bit_r <= wb_dat_i[`CMD_BIT];
                    if (wb_dat_i[`CMD_OP_MSB:0] == `OP_START)
                    begin
                        sda_oe <= 1'b1;
                        state_r <= S_START;
                    end
                    else if (wb_dat_i[`CMD_OP_MSB:0] == `OP_BIT || wb_dat_i[`CMD_OP_MSB:0] == `OP_STOP ||
                             wb_dat_i[`CMD_OP_MSB:0] == `OP_RSTART)
                    begin
                        scl_oe <= 1'b1;
                        state_r <= S_LOW;
                    end
                end
            end
            S_START:
            begin
                cnt_r <= cnt_r + 17'h00001;
                if (cnt_r + 17'h00001 >= start_hold_r)
                begin
                    scl_oe <= 1'b1;
                    cnt_r <= 17'h00000;
                    state_r <= S_IDLE;
                end
            end
            S_LOW:
            begin
                cnt_r <= cnt_r + 17'h00001;
                // Change one count early so the setup left before release is exactly half minus hold
                if (cnt_r + 17'h00001 == hold_eff)
                    sda_oe <= sda_drive_low;
                if (cnt_r + 17'h00001 >= half_r)
                begin
                    scl_oe <= 1'b0;
                    cnt_r <= 17'h00000;
                    state_r <= S_HIGH;
                end
            end
            S_HIGH:
            begin
                // High time starts only once the qualified line is seen high
                if (scl_f)
                begin
                    cnt_r <= cnt_r + 17'h00001;
                    if (cnt_r + 17'h00001 >= high_target)
                    begin
                        cnt_r <= 17'h00000;
                        if (op_r == `OP_BIT)
                        begin
                            rx_r <= sda_f;
                            scl_oe <= 1'b1;
                            state_r <= S_IDLE;
                        end
                        else if (op_r == `OP_STOP)
                        begin
                            sda_oe <= 1'b0;
                            state_r <= S_IDLE;
                        end
                        else
                        begin
                            sda_oe <= 1'b1;
                            state_r <= S_START;
                        end
                    end
                end
            end
            default:
            begin
                state_r <= S_IDLE;
                cnt_r <= 17'h00000;
            end
        endcase
    end
end

// Register file; unmapped addresses ack and read zero
always @(posedge clk or negedge rst_n_r)
begin
    if (!rst_n_r)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        scl_divider_code_r <= `CODE_RST;
        filter_sample_rate_r <= `RATE_RST;
    end
    else
    begin
        wb_ack_o <= bus_req;
        if (wr_req && wb_adr_i == `REG_CTRL)
        begin
            if (wb_sel_i[0])
                scl_divider_code_r <= wb_dat_i[`CTRL_CODE_MSB:`CTRL_CODE_LSB];
            if (wb_sel_i[1])
                filter_sample_rate_r <= wb_dat_i[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
        end
        wb_dat_o <= 32'h00000000;
        if (bus_req && !wb_we_i)
        begin
            case (wb_adr_i)
                `REG_CTRL: wb_dat_o <= {18'h00000, filter_sample_rate_r, 2'b00, scl_divider_code_r};
                `REG_STATUS: wb_dat_o <= {28'h0000000, sda_f, scl_f, rx_r, state_r != S_IDLE};
                `REG_TIMING: wb_dat_o <= {hold_r[15:0], divider_value};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end
end

endmodule // bit_timing_ctrl

// ---- testbench/bit_timing_checker.sv ----
// Port-level timing checks for the bit-timing block
`timescale 1ns/1ps
`include "bit_timing_map.vh"
module bit_timing_checker
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Bus lines
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe
);
    logic [5:0] code_r;
    logic [2:0] op_r;
    logic [15:0] cnt_r;
    logic [15:0] hi_r;
    wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
    // Exact figures are only known for the 160 divider used on the link
    wire c20 = code_r == 6'h20;
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            code_r <= `CODE_RST;
            op_r <= 3'h0;
            cnt_r <= 16'h0000;
            hi_r <= 16'h0000;
        end
        else
        begin
            if (take && wb_adr_i == `REG_CTRL) code_r <= wb_dat_i[5:0];
            if (take && wb_adr_i == `REG_CMD) op_r <= wb_dat_i[2:0];
            cnt_r <= (take && wb_adr_i == `REG_CMD) ? 16'h0000 : cnt_r + {15'h0, cnt_r != 16'hFFFF};
            hi_r <= scl_i ? hi_r + {15'h0, hi_r != 16'hFFFF} : 16'h0000;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence start_tail;
        !scl_oe [*5] ##1 scl_oe;
    endsequence
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("line driven high");
    start_hold_a: assert property ($rose(sda_oe) && op_r == `OP_START && c20 |-> start_tail)
        else $error("start hold wrong");
    clock_low_a: assert property ($fell(scl_oe) && op_r != `OP_START && c20 |-> cnt_r == 16'h0050)
        else $error("clock low period wrong");
    data_hold_a: assert property ($changed(sda_oe) && op_r == `OP_BIT && c20 |-> cnt_r == 16'h0018)
        else $error("data hold wrong");
    clock_high_a: assert property ($rose(scl_oe) && op_r == `OP_BIT && c20 |-> hi_r >= 16'h0052)
        else $error("clock high period short");
    rstart_setup_a: assert property ($rose(sda_oe) && op_r == `OP_RSTART && c20 |-> hi_r >= 16'h00A5)
        else $error("repeated start setup short");
    stop_setup_a: assert property ($fell(sda_oe) && op_r == `OP_STOP |-> hi_r >= 16'h0006)
        else $error("stop setup short");
endmodule // bit_timing_checker

bind bit_timing_ctrl bit_timing_checker u_chk (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

// ---- testbench/bus_partner.sv ----
// Far-side device on the two-wire bus: stretches SCL and pulls SDA
`timescale 1ns/1ps
module bus_partner
(
    // Clock
    input wire logic clk,
    // Pull-downs of the block
    input wire logic scl_oe,
    input wire logic sda_oe,
    // Bench controls
    input wire logic [7:0] stretch,
    input wire logic ack_req,
    // Resolved lines
    output wire logic scl,
    output wire logic sda
);
    logic [7:0] hold_r = 8'h00;
    logic oe_r = 1'b0;
    logic ack_r = 1'b0;
    // Prior enable covers the cycle of release, so a stretch has no high glitch
    assign scl = !(scl_oe | hold_r != 8'h00 | (oe_r & stretch != 8'h00));
    assign sda = !(sda_oe | ack_r);
    always @(posedge clk)
    begin
        oe_r <= scl_oe;
        if (oe_r && !scl_oe) hold_r <= stretch;
        else if (hold_r != 8'h00) hold_r <= hold_r - 8'h01;
        // SDA only moves while SCL is low
        if (!scl) ack_r <= ack_req;
    end
endmodule // bus_partner

// ---- testbench/test_two_wire_bit_timing_divider.sv ----
// Self-checking bench for the bit-timing block
`timescale 1ns/1ps
`include "bit_timing_map.vh"
module test_two_wire_bit_timing_divider;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0;
    logic [7:0] stretch = 8'h00;
    logic ack_req = 1'b0;
    wire [31:0] dat_r;
    wire ack, scl_o, scl_oe, sda_o, sda_oe, scl, sda;
    logic [63:0] expq[$];
    logic [63:0] e;
    logic [31:0] rd;
    logic [31:0] seed = 32'hB7A2;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [5:0] codes [33] = '{6'h20, 6'h1E, 6'h1F, 6'h02, 6'h03, 6'h26, 6'h27, 6'h28, 6'h29, 6'h06, 6'h07,
        6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h0A, 6'h0B, 6'h2E, 6'h2F, 6'h30, 6'h31, 6'h0E, 6'h0F, 6'h32, 6'h33,
        6'h34, 6'h35, 6'h12, 6'h13, 6'h36, 6'h37, 6'h38, 6'h39};
    logic [15:0] divs [33] = '{16'h00A0, 16'hC000, 16'hF000, 16'h0180, 16'h01C0, 16'h01E0, 16'h0200,
        16'h0280, 16'h0300, 16'h0300, 16'h0380, 16'h03C0, 16'h0400, 16'h0500, 16'h0600, 16'h0600, 16'h0700,
        16'h0780, 16'h0800, 16'h0A00, 16'h0C00, 16'h0C00, 16'h0E00, 16'h0F00, 16'h1000, 16'h1400, 16'h1800,
        16'h1800, 16'h1C00, 16'h1E00, 16'h2000, 16'h2800, 16'h3000};
    bit_timing_ctrl dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .scl_i(scl),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    bus_partner peer (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .stretch(stretch), .ack_req(ack_req),
        .scl(scl), .sda(sda));
    always #12.5 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] hold_of(input logic [5:0] c);
        logic [2:0] m;
        m = c[5] ? (c[1] ? 3'h2 : 3'h1) : (c[1] ? 3'h4 : 3'h3);
        return 16'h0008 + (16'h0010 << c[4:2]) * {13'h0, m};
    endfunction
    task check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        if (m == 32'h0) return;
        comparisons++;
        if ((got & m) !== (exp & m))
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wrap_up();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // One classic cycle; a read notes data and compare mask, mask zero only polls
    task bus(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [31:0] m);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat_w <= w ? d : 32'h0;
        if (!w) expq.push_back({m, d});
        // No local limit: only the cycle ceiling ends a wait for ack
        do
        begin
            @(posedge clk);
        end
        while (ack !== 1'b1);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task cmd(input logic [2:0] op, input logic b);
        bus(`REG_CMD, 1'b1, {28'h0, b, op}, 32'h0);
        do
        begin
            bus(`REG_STATUS, 1'b0, 32'h0, 32'h0);
        end
        while (rd[`ST_BUSY] !== 1'b0);
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            wrap_up();
        end
        else if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
        begin
            e = expq.pop_front();
            check(dat_r, e[31:0], e[63:32]);
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        bus(`REG_CTRL, 1'b0, {18'h0, `RATE_RST, 2'h0, `CODE_RST}, 32'hFFFFFFFF);
        bus(4'h2, 1'b1, rnd(), 32'h0);
        bus(4'h2, 1'b0, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 33; i++)
        begin
            bus(`REG_CTRL, 1'b1, {18'h0, i[5:0], 2'h0, codes[i]}, 32'h0);
            bus(`REG_TIMING, 1'b0, {hold_of(codes[i]), divs[i]}, '1);
            bus(`REG_CTRL, 1'b0, {18'h0, i[5:0], 2'h0, codes[i]}, 32'hFFFFFFFF);
        end
        // Mid-run reset has to bring both control fields back
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(`REG_CTRL, 1'b0, {18'h0, `RATE_RST, 2'h0, `CODE_RST}, 32'hFFFFFFFF);
        bus(`REG_CTRL, 1'b1, {18'h0, 6'h01, 2'h0, 6'h20}, 32'h0);
        cmd(`OP_START, 1'b0);
        bus(`REG_STATUS, 1'b0, 32'h0, 32'h0000000D);
        for (int i = 0; i < 4; i++)
        begin
            ack_req <= (i == 3);
            stretch <= (i == 2) ? 8'h3C : 8'h00;
            cmd(`OP_BIT, i[0] ^ rnd() & 1'b0);
            bus(`REG_STATUS, 1'b0, {30'h0, i[0] & (i != 3), 1'b0}, 32'h3);
        end
        ack_req <= 1'b0;
        cmd(`OP_RSTART, 1'b1);
        cmd(`OP_STOP, 1'b0);
        bus(`REG_STATUS, 1'b0, 32'hC, 32'hF);
        wrap_up();
    end
endmodule // test_two_wire_bit_timing_divider
